// File: common/nibble_io_pkg.sv
// constants, types and register map for the nibble i/o port block
package nibble_io_pkg;

    // ***************************************************************
    // register indices (byte address is four times the index)
    // ***************************************************************
    localparam logic [7:0] CE_PORT_DIRECTION_IDX = 8'h01;
    localparam logic [7:0] A_PORT_DIRECTION_IDX  = 8'h02;
    localparam logic [7:0] A_PORT_VALUE_IDX      = 8'h03;
    localparam logic [7:0] C_PORT_OUTPUT_IDX     = 8'h04;
    localparam logic [7:0] CE_PORT_VALUE_IDX     = 8'h04;
    localparam logic [7:0] D_PORT_DIRECTION_IDX  = 8'h0c;
    localparam logic [7:0] D_PORT_VALUE_IDX      = 8'h0d;
    localparam logic [7:0] E_PORT_VALUE_IDX      = 8'h0e;
    localparam logic [7:0] WAKE_STATUS_IDX       = 8'h20;
    localparam logic [7:0] WAKE_CLEAR_IDX        = 8'h21;
    localparam logic [7:0] WAKE_ENABLE_IDX       = 8'h22;

    // ***************************************************************
    // reset values and field positions
    // ***************************************************************
    localparam logic [3:0] DIRECTION_RESET  = 4'h0;
    localparam logic [3:0] PORT_DATA_RESET  = 4'h0;
    localparam logic [2:0] WAKE_REG_RESET   = 3'h0;
    localparam int         CARRIER_BIT      = 3;
    localparam int         ANALOG_WAKE_BIT  = 0;
    localparam int         WAKE_A_BIT       = 0;
    localparam int         WAKE_D_BIT       = 1;
    localparam int         WAKE_CE_BIT      = 2;
    localparam logic [11:0] WAKE_VECTOR     = 12'h004;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int CLK_HZ               = 100_000_000;
    localparam int CARRIER_HZ           = 38_000;
    localparam int CARRIER_HALF_CYCLES  = CLK_HZ / (2 * CARRIER_HZ);

    // ***************************************************************
    // types
    // ***************************************************************
    typedef enum logic [1:0] {
        CE_OUTPUT_ONLY,
        CE_INPUT_ONLY,
        CE_BIDIRECTIONAL
    } ce_port_mode_t;

    typedef struct packed {
        ce_port_mode_t ce_mode;
        logic          double_edge_wake_option;
        logic          ir_carrier_option;
        logic          buzzer_wake_option;
        logic          touch_pulldown_option;
        logic [3:0]    wake_a;
        logic [3:0]    wake_d;
        logic [3:0]    wake_e;
        logic [3:0]    pd_1m_a;
        logic [3:0]    pd_1m_d;
        logic [3:0]    pd_1m_e;
        logic [3:0]    pd_50k_a;
        logic [3:0]    pd_50k_d;
        logic [3:0]    pd_50k_e;
    } mask_options_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe_n;
    } pin_drive_t;

    typedef struct packed {
        logic [3:0] pd_1m;
        logic [3:0] pd_50k;
        logic [3:0] pd_220k;
    } pulldown_t;

endpackage : nibble_io_pkg

// File: src/nibble_io_ports.sv
// nibble i/o ports with halt wake-up, ir carrier and ahb-lite registers
//
// Functional notes
// - Each port is four bits wide, direction is per bit and all directions reset to inputs, except port C in output-only mode, which drives from reset.
// - A direction bit of one makes its pin an output and zero makes it an input.
// - An output pin is driven from the data latch and reads return that latch.
// - Any pull-down on a pin that is an output is switched off.
// - An input pin reads back its external pin level.
// - An input pin gets a 1M or 50K pull-down only when its option selects one.
// - With the touch option on, the 50K pull-down enables connect 220K pull-downs instead.
// - In halt a rising edge on a wake-enabled pin wakes the core to the wake vector.
// - With the double-edge option both edges on wake-enabled pins wake the core.
// - With the carrier option and bit 3 of port A an output, data one emits 38 kHz, zero drives low.
// - With the carrier option on, in halt the carrier pin is forced low to protect an attached ir led.
// - With the carrier option off the carrier pin is an ordinary port pin.
// - With the buzzer wake option on, the 1M and 50K pull-downs of port A bit 0 are off.
// - In output-only mode port C only drives, resets to zero and writes set its pins.
// - In input-only mode all port E pins are inputs with optional pull-downs; the i/o mode makes them bidirectional.
// - The combined c/e direction register acts only in the bidirectional c/e mode.
module nibble_io_ports
    import nibble_io_pkg::*;
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire mask_options_t mask_options,
    input  wire logic          halt_mode,
    input  wire logic [3:0]    a_pin_in,
    input  wire logic [3:0]    d_pin_in,
    input  wire logic [3:0]    ce_pin_in,
    output pin_drive_t         a_pin,
    output pin_drive_t         d_pin,
    output pin_drive_t         ce_pin,
    output pulldown_t          a_pulldown,
    output pulldown_t          d_pulldown,
    output pulldown_t          ce_pulldown,
    output logic               wake_request,
    output logic      [11:0]   wake_pc,
    output logic               irq
);

    // ***************************************************************
    // static mask options
    // ***************************************************************
    mask_options_t opt;
    logic          opt_loaded;
    // loaded once

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opt        <= '0;
            opt_loaded <= 1'b0;
        end else if (!opt_loaded) begin
            opt        <= mask_options;
            opt_loaded <= 1'b1;
        end
    end

    // ***************************************************************
    // ahb-lite slave
    // ***************************************************************
    logic [3:0] a_port_direction;
    logic [3:0] a_port_value;
    logic [3:0] d_port_direction;
    logic [3:0] d_port_value;
    logic [3:0] ce_port_direction;
    logic [3:0] ce_port_value;
    logic [2:0] wake_status;
    logic [2:0] wake_enable;
    logic [3:0] ce_dir_eff;
    logic       wr_pend;
    logic [7:0] wr_idx;
    logic       access;
    logic [7:0] addr_idx;
    logic [31:0] next_hrdata;

    assign access   = hsel && hready && htrans[1];
    assign addr_idx = haddr[9:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx  <= 8'h00;
        end else begin
            wr_pend <= access && hwrite;
            wr_idx  <= addr_idx;
        end
    end

    // read mux
    always_comb begin
        next_hrdata = 32'h0000_0000;
        unique case (addr_idx)
            CE_PORT_DIRECTION_IDX: next_hrdata[3:0] = ce_port_direction;
            A_PORT_DIRECTION_IDX:  next_hrdata[3:0] = a_port_direction;
            A_PORT_VALUE_IDX:
                next_hrdata[3:0] = (a_port_direction & a_port_value)
                                 | (~a_port_direction & a_pin_in);
            CE_PORT_VALUE_IDX:
                next_hrdata[3:0] = (ce_dir_eff & ce_port_value)
                                 | (~ce_dir_eff & ce_pin_in);
            D_PORT_DIRECTION_IDX:  next_hrdata[3:0] = d_port_direction;
            D_PORT_VALUE_IDX:
                next_hrdata[3:0] = (d_port_direction & d_port_value)
                                 | (~d_port_direction & d_pin_in);
            E_PORT_VALUE_IDX:
                next_hrdata[3:0] = (ce_dir_eff & ce_port_value)
                                 | (~ce_dir_eff & ce_pin_in);
            WAKE_STATUS_IDX:       next_hrdata[2:0] = wake_status;
            WAKE_ENABLE_IDX:       next_hrdata[2:0] = wake_enable;
            default:               next_hrdata = 32'h0000_0000;
        endcase
    end

    // zero wait, okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (access && !hwrite) begin
                hrdata <= next_hrdata;
            end
        end
    end

    // ***************************************************************
    // direction and data registers
    // ***************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_port_direction  <= DIRECTION_RESET;
            d_port_direction  <= DIRECTION_RESET;
            ce_port_direction <= DIRECTION_RESET;
        end else if (wr_pend) begin
            // data phase
            if (wr_idx == A_PORT_DIRECTION_IDX) begin
                a_port_direction <= hwdata[3:0];
            end
            if (wr_idx == D_PORT_DIRECTION_IDX) begin
                d_port_direction <= hwdata[3:0];
            end
            if (wr_idx == CE_PORT_DIRECTION_IDX) begin
                ce_port_direction <= hwdata[3:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_port_value  <= PORT_DATA_RESET;
            d_port_value  <= PORT_DATA_RESET;
            ce_port_value <= PORT_DATA_RESET;
        end else if (wr_pend) begin
            if (wr_idx == A_PORT_VALUE_IDX) begin
                a_port_value <= hwdata[3:0];
            end
            if (wr_idx == D_PORT_VALUE_IDX) begin
                d_port_value <= hwdata[3:0];
            end
            if (wr_idx == CE_PORT_VALUE_IDX || wr_idx == E_PORT_VALUE_IDX) begin
                ce_port_value <= hwdata[3:0];
            end
        end
    end

    always_comb begin
        unique case (opt.ce_mode)
            CE_OUTPUT_ONLY:   ce_dir_eff = 4'hf;
            CE_INPUT_ONLY:    ce_dir_eff = 4'h0;
            CE_BIDIRECTIONAL: ce_dir_eff = ce_port_direction;
            default:          ce_dir_eff = 4'h0;
        endcase
    end

    // ***************************************************************
    // 38 khz carrier divider
    // ***************************************************************
    // free running
    logic [15:0] carrier_count;
    logic        carrier_clk;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            carrier_count <= 16'h0000;
            carrier_clk   <= 1'b0;
        end else if (carrier_count == 16'(CARRIER_HALF_CYCLES - 1)) begin
            carrier_count <= 16'h0000;
            carrier_clk   <= ~carrier_clk;
        end else begin
            carrier_count <= carrier_count + 16'h0001;
        end
    end

    // ***************************************************************
    // pin drive and pull-downs
    // ***************************************************************
    logic [3:0] next_a_out;
    pulldown_t  next_a_pd;
    pulldown_t  next_d_pd;
    pulldown_t  next_ce_pd;

    always_comb begin
        next_a_out = a_port_value;
        if (opt.ir_carrier_option) begin
            if (halt_mode) begin
                next_a_out[CARRIER_BIT] = 1'b0;
            end else begin
                next_a_out[CARRIER_BIT] = a_port_value[CARRIER_BIT] & carrier_clk;
            end
        end
    end

    always_comb begin
        // port a
        next_a_pd.pd_1m   = opt.pd_1m_a & ~a_port_direction;
        next_a_pd.pd_50k  = opt.touch_pulldown_option ? 4'h0
                          : (opt.pd_50k_a & ~a_port_direction);
        next_a_pd.pd_220k = opt.touch_pulldown_option
                          ? (opt.pd_50k_a & ~a_port_direction) : 4'h0;
        if (opt.buzzer_wake_option) begin
            next_a_pd.pd_1m[ANALOG_WAKE_BIT]  = 1'b0;
            next_a_pd.pd_50k[ANALOG_WAKE_BIT] = 1'b0;
        end

        // port d
        next_d_pd.pd_1m   = opt.pd_1m_d & ~d_port_direction;
        next_d_pd.pd_50k  = opt.touch_pulldown_option ? 4'h0
                          : (opt.pd_50k_d & ~d_port_direction);
        next_d_pd.pd_220k = opt.touch_pulldown_option
                          ? (opt.pd_50k_d & ~d_port_direction) : 4'h0;

        // port c/e
        next_ce_pd.pd_1m   = opt.pd_1m_e & ~ce_dir_eff;
        next_ce_pd.pd_50k  = opt.touch_pulldown_option ? 4'h0
                           : (opt.pd_50k_e & ~ce_dir_eff);
        next_ce_pd.pd_220k = opt.touch_pulldown_option
                           ? (opt.pd_50k_e & ~ce_dir_eff) : 4'h0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_pin       <= '{out: 4'h0, oe_n: 4'hf};
            d_pin       <= '{out: 4'h0, oe_n: 4'hf};
            ce_pin      <= '{out: 4'h0, oe_n: 4'hf};
            a_pulldown  <= '0;
            d_pulldown  <= '0;
            ce_pulldown <= '0;
        end else if (opt_loaded) begin
            // released until loaded
            a_pin.out    <= next_a_out;
            a_pin.oe_n   <= ~a_port_direction;

            d_pin.out    <= d_port_value;
            d_pin.oe_n   <= ~d_port_direction;

            ce_pin.out   <= ce_port_value;
            ce_pin.oe_n  <= ~ce_dir_eff;

            a_pulldown   <= next_a_pd;
            d_pulldown   <= next_d_pd;
            ce_pulldown  <= next_ce_pd;
        end
    end

    // ***************************************************************
    // halt wake-up edge detect
    // ***************************************************************
    logic [3:0] a_prev;
    logic [3:0] d_prev;
    logic [3:0] ce_prev;
    logic [2:0] wake_hit;

    // edge select
    function automatic logic edge_wake(input logic [3:0] now,
                                       input logic [3:0] prev,
                                       input logic [3:0] enable,
                                       input logic       both);
        logic [3:0] edges;
        edges = now & ~prev;
        if (both) begin
            edges = now ^ prev;
        end
        return |(edges & enable);
    endfunction : edge_wake

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_prev  <= 4'h0;
            d_prev  <= 4'h0;
            ce_prev <= 4'h0;
        end else begin
            a_prev  <= a_pin_in;
            d_prev  <= d_pin_in;
            ce_prev <= ce_pin_in;
        end
    end

    // input pins only
    always_comb begin
        wake_hit = 3'h0;
        if (halt_mode && opt_loaded) begin
            wake_hit[WAKE_A_BIT]  = edge_wake(a_pin_in, a_prev,
                                              opt.wake_a & ~a_port_direction,
                                              opt.double_edge_wake_option);
            wake_hit[WAKE_D_BIT]  = edge_wake(d_pin_in, d_prev,
                                              opt.wake_d & ~d_port_direction,
                                              opt.double_edge_wake_option);
            wake_hit[WAKE_CE_BIT] = edge_wake(ce_pin_in, ce_prev,
                                              opt.wake_e & ~ce_dir_eff,
                                              opt.double_edge_wake_option);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_request <= 1'b0;
            wake_pc      <= 12'h000;
        end else begin
            wake_request <= |wake_hit;
            if (|wake_hit) begin
                wake_pc <= WAKE_VECTOR;
            end
        end
    end

    // ***************************************************************
    // wake status, clear and enable
    // ***************************************************************
    logic [2:0] wake_clear;

    // write one to clear
    assign wake_clear = (wr_pend && wr_idx == WAKE_CLEAR_IDX) ? hwdata[2:0] : 3'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_status <= WAKE_REG_RESET;
        end else begin
            wake_status <= (wake_status & ~wake_clear) | wake_hit;  // set beats clear
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_enable <= WAKE_REG_RESET;
        end else if (wr_pend && wr_idx == WAKE_ENABLE_IDX) begin
            wake_enable <= hwdata[2:0];
        end
    end

    // irq with status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((wake_status & ~wake_clear) | wake_hit) & wake_enable);
        end
    end

endmodule : nibble_io_ports

// File: bench/nibble_io_ports_sva.sv
// assertion checker for the nibble i/o port block
module nibble_io_ports_sva
    import nibble_io_pkg::*;
(
    input wire logic          hclk,
    input wire logic          hresetn,
    input wire logic          hsel,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic [31:0]   hrdata,
    input wire mask_options_t mask_options,
    input wire logic          halt_mode,
    input wire pin_drive_t    a_pin,
    input wire pin_drive_t    ce_pin,
    input wire pulldown_t     a_pulldown,
    input wire logic          wake_request,
    input wire logic [11:0]   wake_pc
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ******
    // sequences and assertions
    // ******
    sequence s_ce_held(m);
        (mask_options.ce_mode == m) [*4];
    endsequence
    sequence s_carrier_halt;
        halt_mode && mask_options.ir_carrier_option;
    endsequence

    AST_NIBBLE_READ: assert property (hrdata[31:4] == 28'h0)
        else $error("read data above bit 3 not zero");
    AST_DIR_BY_WRITE: assert property (
        $changed(a_pin.oe_n) |-> $past(hsel && htrans[1] && hwrite, 3))
        else $error("port a direction changed without a write");
    AST_OUT_NO_PULL: assert property (
        (~a_pin.oe_n & (a_pulldown.pd_1m | a_pulldown.pd_50k | a_pulldown.pd_220k)) == 4'h0)
        else $error("pull-down left on a driving pin");
    AST_PULL_BY_OPTION: assert property (
        ((a_pulldown.pd_1m & ~mask_options.pd_1m_a)
        | (a_pulldown.pd_50k & ~mask_options.pd_50k_a)) == 4'h0)
        else $error("pull-down on without its option");
    AST_TOUCH_SWAP: assert property (
        mask_options.touch_pulldown_option ? a_pulldown.pd_50k == 4'h0
        : a_pulldown.pd_220k == 4'h0)
        else $error("wrong pull-down value selected");
    AST_BUZZER_PA0: assert property (
        mask_options.buzzer_wake_option |-> !a_pulldown.pd_1m[0] && !a_pulldown.pd_50k[0])
        else $error("buzzer wake pin still pulled down");
    AST_HALT_CARRIER_LOW: assert property (s_carrier_halt |=> !a_pin.out[3])
        else $error("carrier pin not low in halt");
    AST_WAKE_IN_HALT: assert property (wake_request |-> $past(halt_mode))
        else $error("wake request outside halt");
    AST_WAKE_VECTOR: assert property (wake_request |=> wake_pc == WAKE_VECTOR)
        else $error("wake vector not loaded");
    AST_CE_OUTPUT_ONLY: assert property (
        s_ce_held(CE_OUTPUT_ONLY) |-> ce_pin.oe_n == 4'h0)
        else $error("output-only port not driving");
    AST_E_INPUT_ONLY: assert property (
        s_ce_held(CE_INPUT_ONLY) |-> ce_pin.oe_n == 4'hf)
        else $error("input-only port driving");
endmodule : nibble_io_ports_sva

// File: bench/nibble_pin_model.sv
// external pin model: drivers, keys, pull-downs and floating wires
module nibble_pin_model
    import nibble_io_pkg::*;
(
    input  wire logic       clk,
    input  wire pin_drive_t drive,
    input  wire pulldown_t  pull,
    input  wire logic [3:0] key,
    input  wire logic [3:0] key_en,
    output logic      [3:0] level
);
    timeunit 1ns;
    timeprecision 100ps;
    // ******
    // wire resolution
    // ******
    logic [3:0] float_q = 4'h5;

    always @(posedge clk) begin
        float_q <= ~float_q; // undriven unpulled wire wanders
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!drive.oe_n[i]) level[i] = drive.out[i];
            else if (key_en[i]) level[i] = key[i];
            else if (pull.pd_1m[i] | pull.pd_50k[i] | pull.pd_220k[i]) level[i] = 1'b0;
            else level[i] = float_q[i];
        end
    end
endmodule : nibble_pin_model

// File: bench/nibble_io_ports_tb.sv
// self-checking bench for the nibble i/o port block
module nibble_io_ports_tb import nibble_io_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic          hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata, rd_v;
    logic [1:0]    htrans = 2'h0;
    logic          hready, hreadyout, hresp, halt_mode = 1'b0, wake_request, irq;
    mask_options_t opts = '0;
    logic [3:0]    a_in, d_in, ce_in, a_key = 4'h0, a_en = 4'h0, ce_key = 4'h0, ce_en = 4'h0;
    pin_drive_t    a_pin, d_pin, ce_pin;
    pulldown_t     a_pd, d_pd, ce_pd;
    logic [11:0]   wake_pc;
    int            n_mismatch = 0, n_tests = 0, n_wake = 0;
    time           t0;

    assign hready = hreadyout;
    nibble_io_ports dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mask_options(opts),
        .halt_mode(halt_mode), .a_pin_in(a_in), .d_pin_in(d_in), .ce_pin_in(ce_in),
        .a_pin(a_pin), .d_pin(d_pin), .ce_pin(ce_pin), .a_pulldown(a_pd), .d_pulldown(d_pd),
        .ce_pulldown(ce_pd), .wake_request(wake_request), .wake_pc(wake_pc), .irq(irq));
    nibble_pin_model a_m (.clk(hclk), .drive(a_pin), .pull(a_pd), .key(a_key),
        .key_en(a_en), .level(a_in));
    nibble_pin_model d_m (.clk(hclk), .drive(d_pin), .pull(d_pd), .key(4'h0),
        .key_en(4'h0), .level(d_in));
    nibble_pin_model ce_m (.clk(hclk), .drive(ce_pin), .pull(ce_pd), .key(ce_key),
        .key_en(ce_en), .level(ce_in));

    // ******
    // bus and check tasks
    // ******
    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        if (wake_request === 1'b1) n_wake++;
    end

    task automatic summarize();
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic pin(input string what, input logic [3:0] seen, input logic [3:0] exp);
        check(what, {28'h0, seen}, {28'h0, exp});
    endtask : pin
    task automatic bus(input logic w, input logic [7:0] idx, input logic [3:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {28'h0, wd};
        do @(posedge hclk); while (hready !== 1'b1);
        rd_v = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [3:0] v);
        bus(1'b1, idx, v);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 4'h0);
        check($sformatf("reg %h", idx), rd_v, exp);
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask : rdc
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : settle
    task automatic do_reset(input mask_options_t o);
        if ($time > 0) @(posedge hclk);
        hresetn <= 1'b0;
        opts <= o;
        halt_mode <= 1'b0;
        a_key <= 4'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        settle(3);
    endtask : do_reset

    // ******
    // scenarios
    // ******
    initial begin
        #500_000;
        n_mismatch++;
        summarize();
    end
    initial begin
        mask_options_t o;
        int k;
        o = '0;
        o.ce_mode = CE_BIDIRECTIONAL;
        o.ir_carrier_option = 1'b1;
        o.buzzer_wake_option = 1'b1;
        o.wake_a = 4'h2;
        o.pd_1m_a = 4'h3;
        o.pd_50k_a = 4'h4;
        o.pd_50k_d = 4'hf;
        do_reset(o);
        rdc(CE_PORT_DIRECTION_IDX, 32'h0);
        rdc(A_PORT_DIRECTION_IDX, 32'h0);
        rdc(D_PORT_DIRECTION_IDX, 32'h0);
        pin("a oe_n", a_pin.oe_n, 4'hf);
        pin("a pd_1m", a_pd.pd_1m, 4'h2);
        pin("a pd_50k", a_pd.pd_50k, 4'h4);
        pin("a pd_220k", a_pd.pd_220k, 4'h0);
        wr(8'h10, 4'hf);
        rdc(8'h10, 32'h0);
        @(posedge hclk);
        a_key <= 4'h8;
        a_en <= 4'h8;
        ce_key <= 4'h1;
        ce_en <= 4'hf;
        wr(A_PORT_DIRECTION_IDX, 4'h5);
        wr(A_PORT_VALUE_IDX, 4'h7);
        wr(D_PORT_DIRECTION_IDX, 4'h3);
        wr(D_PORT_VALUE_IDX, 4'h9);
        wr(CE_PORT_DIRECTION_IDX, 4'h6);
        wr(C_PORT_OUTPUT_IDX, 4'hf);
        settle(2);
        pin("a oe_n", a_pin.oe_n, 4'ha);
        pin("a out", a_pin.out & 4'h5, 4'h5);
        pin("a pd_50k", a_pd.pd_50k, 4'h0);
        pin("d oe_n", d_pin.oe_n, 4'hc);
        pin("d out", d_pin.out & 4'h3, 4'h1);
        pin("d pd_50k", d_pd.pd_50k, 4'hc);
        pin("ce oe_n", ce_pin.oe_n, 4'h9);
        rdc(A_PORT_VALUE_IDX, 32'hd);
        rdc(D_PORT_VALUE_IDX, 32'h1);
        rdc(E_PORT_VALUE_IDX, 32'h7);
        wr(A_PORT_DIRECTION_IDX, 4'h8);
        wr(A_PORT_VALUE_IDX, 4'h8);
        repeat (2) @(a_pin.out[3]);
        t0 = $time;
        @(a_pin.out[3]);
        check("carrier half", 32'(($time - t0) / 10), CARRIER_HALF_CYCLES);
        wr(A_PORT_VALUE_IDX, 4'h0);
        settle(2);
        pin("carrier off", {3'h0, a_pin.out[3]}, 4'h0);
        wr(A_PORT_VALUE_IDX, 4'h8);
        @(posedge hclk);
        halt_mode <= 1'b1;
        settle(2700);
        pin("halt carrier", {3'h0, a_pin.out[3]}, 4'h0);
        wr(WAKE_ENABLE_IDX, 4'h1);
        k = n_wake;
        @(posedge hclk);
        a_key <= 4'h2;
        a_en <= 4'h2;
        settle(3);
        check("wakes", n_wake - k, 32'h1);
        check("wake pc", {20'h0, wake_pc}, {20'h0, WAKE_VECTOR});
        pin("irq", {3'h0, irq}, 4'h1);
        rdc(WAKE_STATUS_IDX, 32'h1);
        @(posedge hclk);
        a_key <= 4'h0;
        settle(3);
        check("falling wake", n_wake - k, 32'h1);
        wr(WAKE_CLEAR_IDX, 4'h1);
        wr(WAKE_ENABLE_IDX, 4'h0);
        settle(2);
        pin("irq clear", {3'h0, irq}, 4'h0);
        rdc(WAKE_STATUS_IDX, 32'h0);
        @(posedge hclk);
        a_key <= 4'h2;
        settle(3);
        pin("irq masked", {3'h0, irq}, 4'h0);
        rdc(WAKE_STATUS_IDX, 32'h1);
        o.ce_mode = CE_OUTPUT_ONLY;
        o.ir_carrier_option = 1'b0;
        o.buzzer_wake_option = 1'b0;
        o.touch_pulldown_option = 1'b1;
        o.double_edge_wake_option = 1'b1;
        do_reset(o);
        pin("ce oe_n", ce_pin.oe_n, 4'h0);
        rdc(C_PORT_OUTPUT_IDX, 32'h0);
        pin("a pd_1m", a_pd.pd_1m, 4'h3);
        pin("a pd_220k", a_pd.pd_220k, 4'h4);
        wr(CE_PORT_DIRECTION_IDX, 4'hf);
        wr(C_PORT_OUTPUT_IDX, 4'h5);
        wr(A_PORT_DIRECTION_IDX, 4'h8);
        wr(A_PORT_VALUE_IDX, 4'h8);
        settle(2);
        pin("ce oe_n", ce_pin.oe_n, 4'h0);
        pin("ce out", ce_pin.out, 4'h5);
        rdc(C_PORT_OUTPUT_IDX, 32'h5);
        k = n_wake;
        @(posedge hclk);
        halt_mode <= 1'b1;
        a_key <= 4'h2;
        settle(3);
        @(posedge hclk);
        a_key <= 4'h0;
        settle(3);
        check("double wakes", n_wake - k, 32'h2);
        pin("plain pin", {3'h0, a_pin.out[3]}, 4'h1);
        o.ce_mode = CE_INPUT_ONLY;
        o.pd_1m_e = 4'hf;
        do_reset(o);
        wr(CE_PORT_DIRECTION_IDX, 4'hf);
        @(posedge hclk);
        ce_key <= 4'ha;
        settle(2);
        pin("e oe_n", ce_pin.oe_n, 4'hf);
        pin("e pd_1m", ce_pd.pd_1m, 4'hf);
        rdc(E_PORT_VALUE_IDX, 32'ha);
        summarize();
    end
endmodule : nibble_io_ports_tb

bind nibble_io_ports nibble_io_ports_sva chk_u (.*);
